/* File: rtl/sof_bank.sv */
/*
  System option and interrupt flag register bank behind an AXI4-Lite slave.
  Assumes all event inputs are synchronous one-cycle pulses or levels on ref_clk.
*/
`default_nettype none
`include "sof_defs.svh"
module sof_bank
  import sof_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Hardware events
  input wire logic low_voltage_detect,
  input wire logic touch_end,
  input wire logic sysclk_fast_enough,
  input wire logic touch_start,
  input wire logic converter_end,
  input wire logic converter_start,
  input wire logic [7:0] port1_pins,
  input wire logic port1_isr_entry,
  input wire logic slow_timer_isr_entry,
  input wire logic slow_clock_tick,
  input wire logic watchdog_timeout,
  // Configuration outputs
  output logic [3:0] port2_drive_enable,
  output logic [1:0] pin1_mode_select,
  output logic [1:0] pin0_mode_select,
  output logic single_wire_serial,
  output logic touch_clock_auto_adjust,
  output logic [1:0] watchdog_period,
  output logic converter_clock_tick,
  output logic [7:0] port1_wake_enable,
  // Flag and command outputs
  output logic low_voltage_flag,
  output logic touch_done_flag,
  output logic converter_done_flag,
  output logic port1_change_flag,
  output logic slow_timer_flag,
  output logic soft_reset_pulse,
  output logic flash_write_permit
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Word hit on a register index; low address bits are ignored
  function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
    reg_hit = (a[11:10] == 2'b00) && (a[9:2] == idx);
  endfunction : reg_hit

  // Any of the five registers
  function automatic logic any_hit(input logic [11:0] a);
    any_hit = reg_hit(a, `SOF_IDX_P2CFG) || reg_hit(a, `SOF_IDX_OPTION)
      || reg_hit(a, `SOF_IDX_FLAGS) || reg_hit(a, `SOF_IDX_WAKE)
      || reg_hit(a, `SOF_IDX_CMD);
  endfunction : any_hit

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sof_wstate_type wstate_reg; // Write channel state
  logic aw_held_reg; // Address captured
  logic w_held_reg; // Data captured
  logic [11:0] waddr_reg; // Captured write address
  logic [7:0] wdata_reg; // Captured low data byte
  logic wstrb_reg; // Low lane strobe
  logic [7:0] p2cfg_reg; // Port 2 pin configuration
  logic [7:0] option_reg; // System option
  logic [7:0] wake_reg; // Port 1 wake enables
  logic [3:0] flag_reg; // Touch, converter, port 1, slow timer
  logic lvd_reg; // Detector level as seen by software
  logic wdt_reg; // Watchdog timeout, read-only copy
  logic permit_reg; // Flash write permit
  logic soft_reset_command_reg; // Software reset pulse
  logic [7:0] pins_prev_reg; // Port 1 pins one cycle ago
  logic [15:0] st_cnt_reg; // Slow timer count
  logic [4:0] div_cnt_reg; // Converter clock divider
  logic conv_tick_reg; // Divided converter clock tick
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  // ----------------------------------------------------------------
  // Combinational terms
  // ----------------------------------------------------------------
  logic wr_go; // Register write happens this cycle
  logic wr_p2cfg, wr_option, wr_flags, wr_wake, wr_cmd;
  logic [15:0] st_period; // Chosen slow timer period
  logic [4:0] div_last; // Last divider count
  logic st_wrap; // Slow timer completes a period
  logic p1_change; // Change seen on an enabled pin
  logic [3:0] set_ev; // Hardware set per flag
  logic [3:0] hw_clr; // Hardware clear per flag
  logic [3:0] sw_clr; // Software write clear per flag
  logic [7:0] flags_view; // Flag register as read

  assign wr_go = (wstate_reg == SOF_W_IDLE) && aw_held_reg && w_held_reg;
  assign wr_p2cfg = wr_go && wstrb_reg && reg_hit(waddr_reg, `SOF_IDX_P2CFG);
  assign wr_option = wr_go && wstrb_reg && reg_hit(waddr_reg, `SOF_IDX_OPTION);
  assign wr_flags = wr_go && wstrb_reg && reg_hit(waddr_reg, `SOF_IDX_FLAGS);
  assign wr_wake = wr_go && wstrb_reg && reg_hit(waddr_reg, `SOF_IDX_WAKE);
  assign wr_cmd = wr_go && wstrb_reg && reg_hit(waddr_reg, `SOF_IDX_CMD);

  // Slow timer period select
  always_comb
  begin
    case (option_reg[1:0])
      2'b00: st_period = `SOF_ST_P0;
      2'b01: st_period = `SOF_ST_P1;
      2'b10: st_period = `SOF_ST_P2;
      default: st_period = `SOF_ST_P3;
    endcase
  end

  // Converter clock ratio select
  always_comb
  begin
    case (option_reg[3:2])
      2'b00: div_last = `SOF_DIV_0;
      2'b01: div_last = `SOF_DIV_1;
      2'b10: div_last = `SOF_DIV_2;
      default: div_last = `SOF_DIV_3;
    endcase
  end

  // A shortened period mid-count wraps on the next slow clock tick rather than running to 64K
  assign st_wrap = slow_clock_tick && (st_cnt_reg >= st_period - 16'h0001);
  assign p1_change = |((pins_prev_reg ^ port1_pins) & wake_reg);

  // Per-flag set and clear sources, order touch, converter, port 1, timer
  assign set_ev = {touch_end && sysclk_fast_enough, converter_end, p1_change, st_wrap};
  assign hw_clr = {touch_start, converter_start, port1_isr_entry, slow_timer_isr_entry};
  assign sw_clr = {4{wr_flags}} & ~{wdata_reg[`SOF_FLG_TOUCH], wdata_reg[`SOF_FLG_CONV],
    wdata_reg[`SOF_FLG_P1], wdata_reg[`SOF_FLG_ST]};

  // Reserved flag bits read as zero
  always_comb
  begin
    flags_view = 8'h00;
    flags_view[`SOF_FLG_LVD] = lvd_reg;
    flags_view[`SOF_FLG_TOUCH] = flag_reg[3];
    flags_view[`SOF_FLG_CONV] = flag_reg[2];
    flags_view[`SOF_FLG_P1] = flag_reg[1];
    flags_view[`SOF_FLG_ST] = flag_reg[0];
  end

  // ----------------------------------------------------------------
  // AXI write channel
  // ----------------------------------------------------------------

  // Address and data are caught in either order, then written together
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wstate_reg <= SOF_W_IDLE;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      waddr_reg <= 12'h000;
      wdata_reg <= 8'h00;
      wstrb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= SOF_OKAY;
    end
    else
    begin
      case (wstate_reg)
        SOF_W_IDLE:
        begin
          // Address side
          if (s_axi_awvalid && awready_reg)
          begin
            aw_held_reg <= 1'b1;
            awready_reg <= 1'b0;
            waddr_reg <= s_axi_awaddr;
          end
          else if (!aw_held_reg)
          begin
            awready_reg <= 1'b1;
          end
          // Data side
          if (s_axi_wvalid && wready_reg)
          begin
            w_held_reg <= 1'b1;
            wready_reg <= 1'b0;
            wdata_reg <= s_axi_wdata[7:0];
            wstrb_reg <= s_axi_wstrb[0];
          end
          else if (!w_held_reg)
          begin
            wready_reg <= 1'b1;
          end
          // Both present: registers update now, answer next cycle
          if (wr_go)
          begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= any_hit(waddr_reg) ? SOF_OKAY : SOF_SLVERR;
            wstate_reg <= SOF_W_RESP;
          end
        end
        SOF_W_RESP:
        begin
          if (s_axi_bready)
          begin
            bvalid_reg <= 1'b0;
            wstate_reg <= SOF_W_IDLE;
          end
        end
        default:
        begin
          wstate_reg <= SOF_W_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------

  // One read at a time; reads have no side effects
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= SOF_OKAY;
    end
    else if (s_axi_arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= any_hit(s_axi_araddr) ? SOF_OKAY : SOF_SLVERR;
      if (reg_hit(s_axi_araddr, `SOF_IDX_P2CFG))
        rdata_reg <= {24'h00_0000, p2cfg_reg};
      else if (reg_hit(s_axi_araddr, `SOF_IDX_OPTION))
        rdata_reg <= {24'h00_0000, option_reg};
      else if (reg_hit(s_axi_araddr, `SOF_IDX_FLAGS))
        rdata_reg <= {24'h00_0000, flags_view};
      else if (reg_hit(s_axi_araddr, `SOF_IDX_WAKE))
        rdata_reg <= {24'h00_0000, wake_reg};
      else if (reg_hit(s_axi_araddr, `SOF_IDX_CMD))
        rdata_reg <= {30'h0000_0000, wdt_reg, permit_reg};
      else
        rdata_reg <= 32'h0000_0000;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
    else if (!rvalid_reg)
    begin
      arready_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------

  // Port 2 drive enables and pin modes; code 11 is stored as written
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      p2cfg_reg <= `SOF_RST_P2CFG;
    else if (wr_p2cfg)
      p2cfg_reg <= wdata_reg;
  end

  // System option
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      option_reg <= `SOF_RST_OPTION;
    else if (wr_option)
      option_reg <= wdata_reg;
  end

  // Port 1 wake enables
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wake_reg <= `SOF_RST_WAKE;
    else if (wr_wake)
      wake_reg <= wdata_reg;
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------

  // Clearable flags: a set in the clearing cycle wins
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_flag
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          flag_reg[g] <= 1'b0;
        else if (set_ev[g])
          flag_reg[g] <= 1'b1;
        else if (hw_clr[g] || sw_clr[g])
          flag_reg[g] <= 1'b0;
      end
    end
  endgenerate

  // Detector level and watchdog timeout are read-only copies
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lvd_reg <= 1'b0;
      wdt_reg <= 1'b0;
    end
    else
    begin
      lvd_reg <= low_voltage_detect;
      wdt_reg <= watchdog_timeout;
    end
  end

  // Previous pin levels; reset to the idle-high port value
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pins_prev_reg <= `SOF_RST_PINS;
    else
      pins_prev_reg <= port1_pins;
  end

  // ----------------------------------------------------------------
  // Software command
  // ----------------------------------------------------------------

  // Reset code leaves the permit untouched; the pulse lasts one cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      permit_reg <= 1'b0;
      soft_reset_command_reg <= 1'b0;
    end
    else
    begin
      soft_reset_command_reg <= wr_cmd && (wdata_reg == `SOF_CMD_SWRESET);
      if (wr_cmd && (wdata_reg != `SOF_CMD_SWRESET))
        permit_reg <= (wdata_reg == `SOF_CMD_FLASH);
    end
  end

  // ----------------------------------------------------------------
  // Slow timer and converter clock
  // ----------------------------------------------------------------

  // Counts slow clock ticks; flag sets on each wrap
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_cnt_reg <= 16'h0000;
    else if (st_wrap)
      st_cnt_reg <= 16'h0000;
    else if (slow_clock_tick)
      st_cnt_reg <= st_cnt_reg + 16'h0001;
  end

  // Converter clock as a one-cycle tick every 32, 16, 8 or 4 cycles
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt_reg <= 5'h00;
      conv_tick_reg <= 1'b0;
    end
    else if (div_cnt_reg >= div_last)
    begin
      div_cnt_reg <= 5'h00;
      conv_tick_reg <= 1'b1;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
      conv_tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign port2_drive_enable = p2cfg_reg[7:4];
  assign pin1_mode_select = p2cfg_reg[3:2];
  assign pin0_mode_select = p2cfg_reg[1:0];
  assign single_wire_serial = option_reg[7];
  assign touch_clock_auto_adjust = option_reg[6];
  assign watchdog_period = option_reg[5:4];
  assign converter_clock_tick = conv_tick_reg;
  assign port1_wake_enable = wake_reg;
  assign low_voltage_flag = lvd_reg;
  assign touch_done_flag = flag_reg[3];
  assign converter_done_flag = flag_reg[2];
  assign port1_change_flag = flag_reg[1];
  assign slow_timer_flag = flag_reg[0];
  assign soft_reset_pulse = soft_reset_command_reg;
  assign flash_write_permit = permit_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_swreset;
    wr_cmd && wdata_reg == `SOF_CMD_SWRESET |=> soft_reset_pulse ##1 !soft_reset_pulse;
  endproperty
  a_swreset: assert property (p_swreset) else $error("reset code gave no single pulse");

  property p_permit;
    wr_cmd && wdata_reg != `SOF_CMD_SWRESET |=> flash_write_permit == ($past(wdata_reg) == `SOF_CMD_FLASH);
  endproperty
  a_permit: assert property (p_permit) else $error("flash permit wrong after command");

  property p_touch;
    touch_start && !(touch_end && sysclk_fast_enough) |=> !touch_done_flag;
  endproperty
  a_touch: assert property (p_touch) else $error("touch start left flag set");

  property p_conv;
    converter_end |=> converter_done_flag;
  endproperty
  a_conv: assert property (p_conv) else $error("conversion end not flagged");

  property p_p1;
    |((port1_pins ^ $past(port1_pins)) & wake_reg) |=> port1_change_flag;
  endproperty
  a_p1: assert property (p_p1) else $error("enabled pin change not flagged");

  property p_p1clr;
    port1_isr_entry && !p1_change |=> !port1_change_flag;
  endproperty
  a_p1clr: assert property (p_p1clr) else $error("service entry left port flag");

  property p_st;
    slow_clock_tick && st_cnt_reg == st_period - 16'h0001 |=> slow_timer_flag && st_cnt_reg == 16'h0000;
  endproperty
  a_st: assert property (p_st) else $error("slow timer period not flagged");

  property p_lvd;
    low_voltage_detect |=> low_voltage_flag;
  endproperty
  a_lvd: assert property (p_lvd) else $error("low voltage not flagged");

  property p_wclr;
    wr_flags && !set_ev[2] && !wdata_reg[`SOF_FLG_CONV] |=> !converter_done_flag;
  endproperty
  a_wclr: assert property (p_wclr) else $error("flag write did not clear");

endmodule : sof_bank
`default_nettype wire

/* File: rtl/sof_defs.svh */
/*
  Offsets, field positions, reset values and counts of the system option and flag bank.
  Assumes inclusion by bare name from the package and the bank module.
*/
`ifndef SOF_DEFS_SVH
`define SOF_DEFS_SVH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SOF_IDX_P2CFG 8'h93
`define SOF_IDX_OPTION 8'h94
`define SOF_IDX_FLAGS 8'h95
`define SOF_IDX_WAKE 8'h96
`define SOF_IDX_CMD 8'h97
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SOF_RST_P2CFG 8'h05
`define SOF_RST_OPTION 8'h00
`define SOF_RST_WAKE 8'h00
`define SOF_RST_PINS 8'hFF
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SOF_FLG_LVD 7
`define SOF_FLG_TOUCH 5
`define SOF_FLG_CONV 4
`define SOF_FLG_P1 1
`define SOF_FLG_ST 0
`define SOF_CMD_WDT 1
`define SOF_CMD_PERMIT 0
// ----------------------------------------------------------------
// Command codes and counts
// ----------------------------------------------------------------
`define SOF_CMD_SWRESET 8'h56
`define SOF_CMD_FLASH 8'h65
`define SOF_ST_P0 16'h8000
`define SOF_ST_P1 16'h4000
`define SOF_ST_P2 16'h2000
`define SOF_ST_P3 16'h0080
`define SOF_DIV_0 5'h1F
`define SOF_DIV_1 5'h0F
`define SOF_DIV_2 5'h07
`define SOF_DIV_3 5'h03
`endif

/* File: rtl/sof_pkg.sv */
/*
  Types shared by the option and flag bank.
  Assumes the constants header sits beside it.
*/
`default_nettype none
`include "sof_defs.svh"
package sof_pkg;
  // Write channel progress
  typedef enum logic [0:0] {SOF_W_IDLE, SOF_W_RESP} sof_wstate_type;
  // AXI response codes
  typedef enum logic [1:0] {SOF_OKAY = 2'b00, SOF_SLVERR = 2'b10} sof_resp_type;
endpackage : sof_pkg
`default_nettype wire

/* File: verification/sof_bank_tb.sv */
/*
  Self-checking bench for the system option and flag bank, driven over AXI4-Lite.
  Assumes the package, constants header and bank module are compiled first.
*/
`default_nettype none
module sof_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic ref_clk = 0;
  logic rst_n = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] wd = '0;
  wire logic [31:0] s_axi_wdata = {24'h00_0000, wd};
  // Only lane 0 carries a register, so the strobe stays fixed
  wire logic [3:0] s_axi_wstrb = 4'h1;
  logic low_voltage_detect = 0, sysclk_fast_enough = 0, watchdog_timeout = 0;
  logic [7:0] port1_pins = 8'hFF;
  // Event pulses, one bit each so a single task drives them all
  logic [6:0] ev = '0;
  wire logic touch_end = ev[0], touch_start = ev[1], converter_end = ev[2], converter_start = ev[3];
  wire logic port1_isr_entry = ev[4], slow_timer_isr_entry = ev[5], slow_clock_tick = ev[6];
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, pin1_mode_select, pin0_mode_select, watchdog_period;
  logic [31:0] s_axi_rdata;
  logic [3:0] port2_drive_enable;
  logic [7:0] port1_wake_enable;
  logic single_wire_serial, touch_clock_auto_adjust, converter_clock_tick, low_voltage_flag;
  logic touch_done_flag, converter_done_flag, port1_change_flag, slow_timer_flag;
  logic soft_reset_pulse, flash_write_permit;
  int fails = 0, n_compared = 0, n_srst = 0, n_tick = 0, t0;
  logic [1:0] r;
  logic [7:0] d;
  // Rows: address, write data, read-back, response
  localparam logic [29:0] ROWS [8] = '{{12'h24C, 8'h0F, 8'h0F, 2'b00}, {12'h24C, 8'hA6, 8'hA6, 2'b00},
    {12'h250, 8'hD7, 8'hD7, 2'b00}, {12'h258, 8'h5A, 8'h5A, 2'b00}, {12'h25C, 8'h65, 8'h01, 2'b00},
    {12'h25C, 8'h12, 8'h00, 2'b00}, {12'h300, 8'h77, 8'h00, 2'b10}, {12'h25C, 8'h65, 8'h01, 2'b00}};
  // Flag write pattern beside the flags left afterwards
  localparam logic [15:0] CLR [4] = '{16'hDF13, 16'hEF03, 16'hFD01, 16'hFE00};
  sof_bank sof_bank_i (.*);
  // ----------------------------------------
  // Clock and pulse counters
  // ----------------------------------------
  always #2.5 ref_clk = ~ref_clk;
  // Counted every edge so short pulses are never missed
  always @(posedge ref_clk)
  begin
    n_srst <= n_srst + int'(soft_reset_pulse === 1'b1);
    n_tick <= n_tick + int'(converter_clock_tick === 1'b1);
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait: a hung handshake ends the run
  task automatic guard(inout int n);
    n++;
    if (n > 200)
    begin
      fails++;
      print_verdict();
    end
  endtask : guard
  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] resp);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 0;
    w = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    wd <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w))
    begin
      @(posedge ref_clk);
      guard(n);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
      begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1)
      begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    while (s_axi_bvalid !== 1'b1)
    begin
      @(posedge ref_clk);
      guard(n);
    end
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] v, output logic [1:0] resp);
    int n;
    logic got;
    n = 0;
    got = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!(got && s_axi_rvalid === 1'b1))
    begin
      @(posedge ref_clk);
      guard(n);
      if (!got && s_axi_arready === 1'b1)
      begin
        got = 1;
        s_axi_arvalid <= 0;
      end
    end
    v = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : rd
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    rd(a, d, r);
    chk(32'(d), 32'(e));
  endtask : rc
  // One-cycle event pulse, low again for a cycle before the next
  task automatic pulse(input int b);
    @(posedge ref_clk);
    ev[b] <= 1;
    @(posedge ref_clk);
    ev[b] <= 0;
  endtask : pulse
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1;
    for (int i = 0; i < 5; i++)
      rc(12'(12'h24C + 4 * i), i == 0 ? 8'h05 : 8'h00);
    foreach (ROWS[i])
    begin
      wr(ROWS[i][29:18], ROWS[i][17:10], r);
      chk(32'(r), 32'(ROWS[i][1:0]));
      rd(ROWS[i][29:18], d, r);
      chk(32'({d, r}), 32'(ROWS[i][9:0]));
    end
    chk(32'({port2_drive_enable, pin1_mode_select, pin0_mode_select}), 32'h0000_00A6);
    chk(32'({single_wire_serial, touch_clock_auto_adjust, watchdog_period}), 32'h0000_000D);
    chk(32'({port1_wake_enable, flash_write_permit}), 32'h0000_00B5);
    // Disabled pin change, unclocked touch end and 127 ticks must set nothing
    port1_pins <= 8'hFE;
    pulse(0);
    repeat (127) pulse(6);
    rc(12'h254, 8'h00);
    sysclk_fast_enough <= 1;
    pulse(0);
    pulse(2);
    port1_pins <= 8'hFC;
    pulse(6);
    rc(12'h254, 8'h33);
    chk(32'({touch_done_flag, converter_done_flag, port1_change_flag, slow_timer_flag}), 32'h0000_000F);
    foreach (CLR[i])
    begin
      wr(12'h254, CLR[i][15:8], r);
      rc(12'h254, CLR[i][7:0]);
    end
    // Set again, then clear through starts and service entries
    pulse(0);
    pulse(2);
    port1_pins <= 8'hFE;
    repeat (128) pulse(6);
    rc(12'h254, 8'h33);
    for (int b = 1; b < 6; b += (b == 1) ? 2 : 1)
      pulse(b);
    rc(12'h254, 8'h00);
    // Divider and watchdog codes
    for (int c = 0; c < 4; c++)
    begin
      wr(12'h250, 8'(c * 20), r);
      repeat (40) @(posedge ref_clk);
      t0 = n_tick;
      repeat (320) @(posedge ref_clk);
      chk(32'(n_tick - t0), 32'(10 << c));
      chk(32'(watchdog_period), 32'(c));
    end
    // Slow timer rates 00 to 10, tick held high so the long periods stay short
    for (int c = 0; c < 3; c++)
    begin
      wr(12'h250, 8'(c), r);
      ev[6] <= 1;
      repeat ((32768 >> c) - 1) @(posedge ref_clk);
      ev[6] <= 0;
      rc(12'h254, 8'h00);
      pulse(6);
      rc(12'h254, 8'h01);
      wr(12'h254, 8'hFE, r);
    end
    // Low-voltage flag ignores writes
    low_voltage_detect <= 1;
    wr(12'h254, 8'h00, r);
    rc(12'h254, 8'h80);
    chk(32'(low_voltage_flag), 32'h0000_0001);
    low_voltage_detect <= 0;
    wr(12'h25C, 8'h56, r);
    repeat (3) @(posedge ref_clk);
    chk(32'({n_srst, flash_write_permit}), 32'h0000_0003);
    watchdog_timeout <= 1;
    rc(12'h25C, 8'h03);
    // Second reset in mid-run
    rst_n <= 0;
    repeat (3) @(posedge ref_clk);
    chk(32'({flash_write_permit, port2_drive_enable}), 32'h0000_0000);
    rst_n <= 1;
    rc(12'h25C, 8'h02);
    print_verdict();
  end
endmodule : sof_bank_tb
`default_nettype wire
